// *** hdl/adc_conversion_output_control.sv ***
// digital control of a dual-slope converter: phases, status, output latch and byte bus
// assumes pins arrive asynchronously and are synchronised here; AXI4-Lite on aclk
// Function
// - mode input low or open selects direct output mode
// - high pulse on mode sends result as two handshake bytes, then direct mode
// - mode held high gives a handshake output after every conversion that ends with no handshake in progress
// - status rises at the start of signal integrate
// - status falls one step after the new result is latched
// - latch contents never change while status is low
// - gate high runs conversions back to back, latching after zero crossing
// - continuous conversion cycle lasts exactly 8192 clocks
// - gate low after zero crossing ends deintegrate at once, into auto-zero
// - gate low keeps auto-zero past its minimum until gate is high
// - integrate and status start seven clocks after gate is seen high
// - gate low during auto-zero stops at its end until gate returns high
// - low byte holds bits 1-8; high byte bits 9-12, sign, over-range
// - chip and byte enables are active low, idle high when open
// - in direct mode, chip enable low plus byte enable low drives that byte, else three-state
// - enable pins pass the two-flop synchroniser, so their effect lags the pins by two clocks
// - 12-bit counter with sign and over-range captured into output latches
// - handshake ignores mode and blocks latch updates until bytes are sent
// - handshake or mode high turns enable pins into driven outputs
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_output_control
(
   input  wire logic                                aclk,
   input  wire logic                                aresetn,
   input  wire logic [adc_ctrl_pkg::AXI_ADDR_W-1:0] awaddr,
   input  wire logic                                awvalid,
   output var  logic                                awready,
   input  wire logic [adc_ctrl_pkg::AXI_DATA_W-1:0] wdata,
   input  wire logic [3:0]                          wstrb,
   input  wire logic                                wvalid,
   output var  logic                                wready,
   output var  logic [1:0]                          bresp,
   output var  logic                                bvalid,
   input  wire logic                                bready,
   input  wire logic [adc_ctrl_pkg::AXI_ADDR_W-1:0] araddr,
   input  wire logic                                arvalid,
   output var  logic                                arready,
   output var  logic [adc_ctrl_pkg::AXI_DATA_W-1:0] rdata,
   output var  logic [1:0]                          rresp,
   output var  logic                                rvalid,
   input  wire logic                                rready,
   input  wire logic                                conversion_gate,
   input  wire logic                                comparator,
   input  wire logic                                output_mode,
   input  wire logic                                send,
   input  wire logic                                chip_enable_n_in,
   output var  logic                                chip_enable_n_out,
   output var  logic                                chip_enable_n_oe,
   input  wire logic                                low_byte_enable_n_in,
   output var  logic                                low_byte_enable_n_out,
   output var  logic                                low_byte_enable_n_oe,
   input  wire logic                                high_byte_enable_n_in,
   output var  logic                                high_byte_enable_n_out,
   output var  logic                                high_byte_enable_n_oe,
   output var  logic [adc_ctrl_pkg::LOW_BYTE_W-1:0] low_byte_data,
   output var  logic                                low_byte_oe,
   output var  logic [adc_ctrl_pkg::HIGH_BYTE_W-1:0] high_byte_data,
   output var  logic                                high_byte_oe,
   output var  logic                                status,
   output var  logic                                phase_autozero,
   output var  logic                                phase_integrate,
   output var  logic                                phase_deintegrate
);
   import adc_ctrl_pkg::*;

   logic [SYNC_W-1:0]      sync1_q;
   logic [SYNC_W-1:0]      sync2_q;
   logic                   mode_dly_q;
   logic [31:0]            ctrl_q;
   phase_type              phase_q;
   phase_type              phase_d;
   hs_type                 hs_q;
   logic [PHASE_CNT_W-1:0] cnt_q;
   logic                   sign_q;
   logic                   zc_q;
   logic                   status_q;
   logic                   latch_event;
   logic                   latch_event_q;
   logic                   latch_we;
   logic [LATCH_W-1:0]     latch_data;
   logic [LATCH_W-1:0]     latch_q;
   logic                   gate;
   logic                   comp;
   logic                   mode_s;
   logic                   send_s;
   logic                   mode_rise;
   logic                   hs_active;
   logic                   direct;
   logic                   zc_now;
   logic                   aw_hold_q;
   logic                   w_hold_q;
   logic [AXI_ADDR_W-1:0]  aw_addr_q;
   logic [AXI_DATA_W-1:0]  w_data_q;
   logic                   w_strb0_q;

   // two-flop pin synchronisers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q <= SYNC_RESET;
         sync2_q <= SYNC_RESET;
      end
      else
      begin
         sync1_q <= {high_byte_enable_n_in, low_byte_enable_n_in, chip_enable_n_in, send,
                     output_mode, comparator, conversion_gate};
         sync2_q <= sync1_q;
      end
   end

   assign gate   = sync2_q[SY_GATE] & ctrl_q[CTRL_RUN_BIT];
   assign comp   = sync2_q[SY_COMP];
   assign mode_s = sync2_q[SY_MODE];
   assign send_s = sync2_q[SY_SEND];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_dly_q <= 1'b0;
      else
         mode_dly_q <= mode_s;
   end

   assign mode_rise = mode_s & ~mode_dly_q;
   assign hs_active = (hs_q != HS_IDLE);

   // phase sequencer
   assign zc_now = (phase_q == PH_DEINTEGRATE) && !zc_q && (comp != sign_q);

   always_comb
   begin
      phase_d = phase_q;
      unique case (phase_q)
         PH_AUTOZERO:
         begin
            if (gate && cnt_q == PHASE_CNT_W'(AZ_CLKS - 1))
               phase_d = PH_INTEGRATE;
            else if (!gate && cnt_q >= PHASE_CNT_W'(MIN_AZ_CLKS - 1))
               phase_d = PH_HOLD;
         end
         PH_HOLD:
         begin
            if (gate)
               phase_d = PH_START;
         end
         PH_START:
         begin
            if (cnt_q == PHASE_CNT_W'(HOLD_START_DELAY - 2))
               phase_d = PH_INTEGRATE;
         end
         PH_INTEGRATE:
         begin
            if (cnt_q == PHASE_CNT_W'(INT_CLKS - 1))
               phase_d = PH_DEINTEGRATE;
         end
         PH_DEINTEGRATE:
         begin
            if ((zc_q && !gate) || cnt_q == PHASE_CNT_W'(DEINT_CLKS - 1))
               phase_d = PH_AUTOZERO;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase_q <= PH_AUTOZERO;
         cnt_q   <= '0;
      end
      else
      begin
         phase_q <= phase_d;
         cnt_q   <= (phase_d != phase_q) ? '0 : cnt_q + 1'b1;
      end
   end

   // sign and zero crossing
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sign_q <= 1'b0;
         zc_q   <= 1'b0;
      end
      else
      begin
         if (phase_q == PH_INTEGRATE && phase_d == PH_DEINTEGRATE)
            sign_q <= comp;
         if (phase_q != PH_DEINTEGRATE)
            zc_q <= 1'b0;
         else if (zc_now)
            zc_q <= 1'b1;
      end
   end

   // latch on zero crossing, or over-range at deintegrate end
   assign latch_event = zc_now ||
                        (phase_q == PH_DEINTEGRATE && !zc_q &&
                         cnt_q == PHASE_CNT_W'(DEINT_CLKS - 1));
   assign latch_we    = latch_event && !hs_active;
   assign latch_data  = {~zc_now, sign_q, cnt_q[CNT_W-1:0]};

   result_latch #(.WIDTH(LATCH_W)) u_latch
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (latch_we),
      .wr_data (latch_data),
      .data_q  (latch_q)
   );

   // status flag
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_q      <= 1'b0;
         latch_event_q <= 1'b0;
      end
      else
      begin
         latch_event_q <= latch_event;
         if (phase_d == PH_INTEGRATE && phase_q != PH_INTEGRATE)
            status_q <= 1'b1;
         else if (latch_event_q)
            status_q <= 1'b0;
      end
   end

   assign status            = status_q;
   assign phase_autozero    = (phase_q == PH_AUTOZERO) || (phase_q == PH_HOLD) ||
                              (phase_q == PH_START);
   assign phase_integrate   = (phase_q == PH_INTEGRATE);
   assign phase_deintegrate = (phase_q == PH_DEINTEGRATE);

   // handshake byte sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hs_q <= HS_IDLE;
      else
      begin
         unique case (hs_q)
            HS_IDLE:
            begin
               if (mode_rise || (mode_s && latch_we))
                  hs_q <= HS_HI_WAIT;
            end
            HS_HI_WAIT:
            begin
               if (send_s)
                  hs_q <= HS_HI_LOAD;
            end
            HS_HI_LOAD:
               hs_q <= HS_HI_HOLD;
            HS_HI_HOLD:
            begin
               if (send_s)
                  hs_q <= HS_LO_LOAD;
            end
            HS_LO_LOAD:
               hs_q <= HS_LO_HOLD;
            HS_LO_HOLD:
            begin
               if (send_s)
                  hs_q <= HS_IDLE;
            end
         endcase
      end
   end

   // byte bus and enable pins
   assign direct = !hs_active && !mode_s;
   assign chip_enable_n_oe      = hs_active || mode_s;
   assign low_byte_enable_n_oe  = hs_active || mode_s;
   assign high_byte_enable_n_oe = hs_active || mode_s;
   assign chip_enable_n_out      = !(hs_q == HS_HI_LOAD || hs_q == HS_LO_LOAD);
   assign high_byte_enable_n_out = !(hs_q == HS_HI_LOAD || hs_q == HS_HI_HOLD);
   assign low_byte_enable_n_out  = !(hs_q == HS_LO_LOAD || hs_q == HS_LO_HOLD);
   assign low_byte_oe  = direct ? (!sync2_q[SY_CE] && !sync2_q[SY_LBE])
                                : !low_byte_enable_n_out;
   assign high_byte_oe = direct ? (!sync2_q[SY_CE] && !sync2_q[SY_HBE])
                                : !high_byte_enable_n_out;
   assign low_byte_data  = latch_q[LOW_BYTE_W-1:0];
   assign high_byte_data = latch_q[LATCH_W-1:LOW_BYTE_W];

   // AXI4-Lite write channel
   assign awready = !aw_hold_q && !bvalid;
   assign wready  = !w_hold_q && !bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb0_q <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
         ctrl_q    <= CTRL_RESET;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_hold_q  <= 1'b1;
            w_data_q  <= wdata;
            w_strb0_q <= wstrb[0];
         end
         if (aw_hold_q && w_hold_q && !bvalid)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid    <= 1'b1;
            if (aw_addr_q == CTRL_OFFSET)
            begin
               bresp <= RESP_OKAY;
               if (w_strb0_q)
                  ctrl_q[CTRL_RUN_BIT] <= w_data_q[CTRL_RUN_BIT];
            end
            else if (aw_addr_q == STATE_OFFSET || aw_addr_q == RESULT_OFFSET)
               bresp <= RESP_OKAY;
            else
               bresp <= RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read channel
   assign arready = !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= RESP_OKAY;
         unique case (araddr)
            CTRL_OFFSET:   rdata <= ctrl_q;
            STATE_OFFSET:  rdata <= {25'h0, hs_active, 3'(phase_q), zc_q, sign_q, status_q};
            RESULT_OFFSET: rdata <= {18'h0, latch_q};
            default:
            begin
               rdata <= '0;
               rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   // checking helpers: cycle length while the gate stays high
   logic [PHASE_CNT_W:0] cyc_cnt_q;
   logic                 cyc_clean_q;
   logic                 int_start;

   assign int_start = (phase_d == PH_INTEGRATE) && (phase_q != PH_INTEGRATE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cyc_cnt_q   <= '0;
         cyc_clean_q <= 1'b0;
      end
      else if (int_start)
      begin
         cyc_cnt_q   <= (PHASE_CNT_W + 1)'(1);
         cyc_clean_q <= gate;
      end
      else
      begin
         cyc_cnt_q <= cyc_cnt_q + 1'b1;
         if (!gate)
            cyc_clean_q <= 1'b0;
      end
   end

   sequence seq_gate_seen;
      phase_q == PH_HOLD && gate;
   endsequence

   sequence seq_start_done;
      ##7 (phase_q == PH_INTEGRATE && status_q);
   endsequence

   AST_START_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
      seq_gate_seen |-> seq_start_done)
      else $error("integrate did not start seven clocks after gate");

   AST_STATUS_RISE: assert property (@(posedge aclk) disable iff (!aresetn)
      int_start |=> status_q && phase_q == PH_INTEGRATE)
      else $error("status not high at integrate start");

   AST_STATUS_FALL: assert property (@(posedge aclk) disable iff (!aresetn)
      latch_we |=> ##1 !status_q)
      else $error("status not low after latch update");

   AST_LATCH_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
      !status_q && $past(!status_q) |-> $stable(latch_q))
      else $error("latch changed while status low");

   AST_GATE_CUT: assert property (@(posedge aclk) disable iff (!aresetn)
      phase_q == PH_DEINTEGRATE && zc_q && !gate |=> phase_q == PH_AUTOZERO && cnt_q == '0)
      else $error("deintegrate not ended after gate low");

   AST_CYCLE_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
      int_start && cyc_clean_q && gate |-> cyc_cnt_q == (PHASE_CNT_W + 1)'(CYCLE_CLKS))
      else $error("continuous cycle length wrong");

   AST_HS_INHIBIT: assert property (@(posedge aclk) disable iff (!aresetn)
      hs_active |=> $stable(latch_q))
      else $error("latch updated during handshake");

   AST_HS_LOAD_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
      hs_q == HS_HI_LOAD |-> !chip_enable_n_out && high_byte_oe ##1
      (chip_enable_n_out && !high_byte_enable_n_out))
      else $error("handshake load pulse not one clock");

   AST_DIRECT_OE: assert property (@(posedge aclk) disable iff (!aresetn)
      direct && (sync2_q[SY_CE] || sync2_q[SY_LBE]) |-> !low_byte_oe)
      else $error("low byte driven without enables");

   AST_PIN_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(hs_active) |-> chip_enable_n_oe && chip_enable_n_out)
      else $error("enable pins not driven in handshake");

endmodule
`default_nettype wire

// *** hdl/adc_ctrl_pkg.sv ***
// constants, states and register map of the converter control block
// assumes a single 20 MHz converter clock and an AXI4-Lite register bus
package adc_ctrl_pkg;

   localparam int CLK_PERIOD_NS    = 50;
   localparam int CYCLE_CLKS       = 8192;
   localparam int INT_CLKS         = 2048;
   localparam int DEINT_CLKS       = 4096;
   localparam int AZ_CLKS          = CYCLE_CLKS - INT_CLKS - DEINT_CLKS;
   localparam int HOLD_START_DELAY = 7;
   localparam int MIN_AZ_CLKS      = AZ_CLKS - HOLD_START_DELAY;
   localparam int CNT_W            = 12;
   localparam int PHASE_CNT_W      = 13;
   localparam int LATCH_W          = CNT_W + 2;
   localparam int LOW_BYTE_W       = 8;
   localparam int HIGH_BYTE_W      = LATCH_W - LOW_BYTE_W;
   localparam int SYNC_W           = 7;

   localparam int AXI_ADDR_W       = 8;
   localparam int AXI_DATA_W       = 32;
   localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
   localparam logic [7:0]  STATE_OFFSET  = 8'h04;
   localparam logic [7:0]  RESULT_OFFSET = 8'h08;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
   localparam int          CTRL_RUN_BIT  = 0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // pin synchroniser slots
   localparam int SY_GATE = 0;
   localparam int SY_COMP = 1;
   localparam int SY_MODE = 2;
   localparam int SY_SEND = 3;
   localparam int SY_CE   = 4;
   localparam int SY_LBE  = 5;
   localparam int SY_HBE  = 6;
   localparam logic [6:0] SYNC_RESET = 7'h70;

   typedef enum {PH_AUTOZERO, PH_HOLD, PH_START, PH_INTEGRATE, PH_DEINTEGRATE} phase_type;
   typedef enum {HS_IDLE, HS_HI_WAIT, HS_HI_LOAD, HS_HI_HOLD, HS_LO_LOAD, HS_LO_HOLD} hs_type;

endpackage

// *** hdl/result_latch.sv ***
// output latch holding count, sign and over-range
// assumes the writer only strobes wr_en while the status output is high
`timescale 1ns/1ps
`default_nettype none
module result_latch
#(
   parameter int WIDTH = 14
)
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   output var  logic [WIDTH-1:0] data_q
);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         data_q <= '0;
      else if (wr_en)
         data_q <= wr_data;
   end

endmodule
`default_nettype wire

// *** verif/bus_host_model.sv ***
// host side of the byte bus: enable wires with pullups, released data lines
// assumes requests come from the bench on clock edges; 1 on req_n means released
`timescale 1ns/1ps
`default_nettype none
module bus_host_model
(
   input  wire logic       aclk,
   input  wire logic [2:0] req_n,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   output var  logic [2:0] pin_in,
   input  wire logic [7:0] lo_data,
   input  wire logic       lo_oe,
   input  wire logic [5:0] hi_data,
   input  wire logic       hi_oe,
   output var  logic [7:0] lo_bus,
   output var  logic [5:0] hi_bus
);
   logic [7:0] lo_q = 8'h00;
   logic [5:0] hi_q = 6'h00;
   // driven pin wins, else host level or pullup
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         pin_in[i] = pin_oe[i] ? pin_out[i] : req_n[i];
   end
   // released lines toggle each clock between the last value and its inverse
   always_ff @(posedge aclk)
   begin
      lo_q <= lo_oe ? lo_data : ~lo_q;
      hi_q <= hi_oe ? hi_data : ~hi_q;
   end
   assign lo_bus = lo_oe ? lo_data : ~lo_q;
   assign hi_bus = hi_oe ? hi_data : ~hi_q;
endmodule
`default_nettype wire

// *** verif/tb_adc_conversion_output_control.sv ***
// self-checking bench: AXI-Lite registers, run/hold timing, byte bus, handshake
// assumes the host model resolves enable wires and released data lines
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_output_control;
   import adc_ctrl_pkg::*;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr;
   logic        conversion_gate = 1'h1, comparator = 1'h1, output_mode = 1'h0, send = 1'h0;
   logic [2:0]  req_n = 3'h7, pin_in;
   logic        chip_enable_n_out, chip_enable_n_oe, low_byte_enable_n_out;
   logic        low_byte_enable_n_oe, high_byte_enable_n_out, high_byte_enable_n_oe;
   logic [7:0]  low_byte_data, lo_bus;
   logic [5:0]  high_byte_data, hi_bus;
   logic        low_byte_oe, high_byte_oe, status;
   logic        phase_autozero, phase_integrate, phase_deintegrate;
   int          fail_count = 0, checks_done = 0, kz = 5000, dcnt = 0, n, na;

   adc_conversion_output_control adc_conversion_output_control_i
   (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .conversion_gate, .comparator, .output_mode, .send,
      .chip_enable_n_in(pin_in[0]), .chip_enable_n_out, .chip_enable_n_oe,
      .low_byte_enable_n_in(pin_in[1]), .low_byte_enable_n_out, .low_byte_enable_n_oe,
      .high_byte_enable_n_in(pin_in[2]), .high_byte_enable_n_out, .high_byte_enable_n_oe,
      .low_byte_data, .low_byte_oe, .high_byte_data, .high_byte_oe, .status,
      .phase_autozero, .phase_integrate, .phase_deintegrate
   );
   bus_host_model bus_host_model_i
   (
      .aclk, .req_n, .pin_in,
      .pin_out({high_byte_enable_n_out, low_byte_enable_n_out, chip_enable_n_out}),
      .pin_oe({high_byte_enable_n_oe, low_byte_enable_n_oe, chip_enable_n_oe}),
      .lo_data(low_byte_data), .lo_oe(low_byte_oe), .lo_bus,
      .hi_data(high_byte_data), .hi_oe(high_byte_oe), .hi_bus
   );

   initial
   begin
      forever #25 aclk = ~aclk;
   end
   // integrator model: crossing kz clocks into deintegrate
   always @(posedge aclk)
   begin
      dcnt <= phase_deintegrate ? dcnt + 1 : 0;
      comparator <= !(phase_deintegrate && dcnt >= kz);
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tmo(input string nm);
      fail_count++;
      $display("CHECK FAILED %s expected answer seen timeout", nm);
      report_and_stop();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
      checks_done++;
      if ((g >= lo && g <= hi) !== 1'h1)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k)
      begin
         @(posedge aclk);
         #1;
      end
   endtask
   function automatic logic sel(input int s);
      case (s)
         0: return status;
         1: return phase_autozero;
         2: return phase_deintegrate;
         3: return high_byte_oe;
         4: return low_byte_oe;
         default: return high_byte_enable_n_oe;
      endcase
   endfunction
   task automatic wait_on(input int s, input logic v, input int lim);
      n = 0;
      while (sel(s) !== v)
      begin
         tick(1);
         n++;
         if (n > lim)
            tmo("wait");
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int i = 0; i < 100; i++)
      begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         rr = bresp;
         tick(1);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tb)
            return;
      end
      tmo("bvalid");
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic ta, tr;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int i = 0; i < 100; i++)
      begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         rv = rdata;
         rr = rresp;
         tick(1);
         if (ta) arvalid <= 1'h0;
         if (tr)
            return;
      end
      tmo("rvalid");
   endtask
   task automatic host(input logic [2:0] r);
      req_n <= r;
      tick(5);
   endtask

   initial
   begin
      tick(4);
      aresetn <= 1'h1;
      chk("status_rst", 1'h0, status);
      chk("az_rst", 1'h1, phase_autozero);
      axi_rd(CTRL_OFFSET);
      chk("ctrl", CTRL_RESET, rv);
      chk("ctrl_resp", RESP_OKAY, rr);
      axi_wr(CTRL_OFFSET, 32'h0);
      axi_rd(CTRL_OFFSET);
      chk("ctrl_off", 32'h0, rv);
      axi_wr(CTRL_OFFSET, 32'h1);
      axi_rd(8'h10);
      chk("bad_rd", RESP_SLVERR, rr);
      axi_wr(8'h10, 32'h0);
      chk("bad_wr", RESP_SLVERR, rr);
      axi_wr(RESULT_OFFSET, 32'hFFFF);
      chk("ro_wr", RESP_OKAY, rr);
      $display("test registers done");
      wait_on(0, 1'h1, 9000);
      chk("integ", 1'h1, phase_integrate);
      wait_on(0, 1'h0, 9000);
      na = n;
      wait_on(0, 1'h1, 9000);
      chk("period", 8192, na + n);
      wait_on(0, 1'h0, 9000);
      axi_rd(RESULT_OFFSET);
      chk("result", 32'h2FFF, rv & 32'h2FFF);
      host(3'h0);
      chk("lo_byte", 8'hFF, lo_bus);
      chk("hi_byte", 6'h2F, hi_bus & 6'h2F);
      host(3'h5);
      chk("lo_oe_noce", 1'h0, low_byte_oe);
      chk("hi_oe_noce", 1'h0, high_byte_oe);
      host(3'h2);
      tick(1000);
      chk("hi_stable", 6'h2F, hi_bus & 6'h2F);
      chk("lo_oe_nolbe", 1'h0, low_byte_oe);
      chk("st_low", 1'h0, status);
      host(3'h7);
      chk("lo_oe_off", 1'h0, low_byte_oe);
      $display("test continuous done");
      kz = 1000;
      wait_on(0, 1'h1, 9000);
      wait_on(2, 1'h1, 3000);
      wait_on(0, 1'h0, 2000);
      axi_rd(RESULT_OFFSET);
      chk_rng("count", 998, 1004, rv & 32'h2FFF);
      conversion_gate <= 1'h0;
      wait_on(1, 1'h1, 10);
      chk_rng("az_jump", 1, 5, n);
      tick(3000);
      chk("hold_az", 1'h1, phase_autozero);
      chk("hold_st", 1'h0, status);
      conversion_gate <= 1'h1;
      wait_on(0, 1'h1, 30);
      chk_rng("start", 9, 10, n);
      $display("test run hold done");
      wait_on(0, 1'h0, 9000);
      output_mode <= 1'h1;
      tick(3);
      output_mode <= 1'h0;
      wait_on(5, 1'h1, 10);
      chk("hs_wait", 1'h0, high_byte_oe);
      send <= 1'h1;
      wait_on(3, 1'h1, 10);
      chk("high_byte_enable_n_out", 1'h0, high_byte_enable_n_out);
      chk("ce_out", 1'h0, chip_enable_n_out);
      chk("hs_hi", 6'h03, hi_bus & 6'h2F);
      wait_on(4, 1'h1, 10);
      chk_rng("hs_lo", 230, 236, lo_bus);
      chk("low_byte_enable_n_out", 1'h0, low_byte_enable_n_out);
      wait_on(5, 1'h0, 20);
      chk("direct", 1'h0, chip_enable_n_oe);
      $display("test handshake done");
      send <= 1'h0;
      output_mode <= 1'h1;
      kz = 2000;
      tick(4);
      chk("hs_hold", 1'h0, high_byte_oe);
      chk("low_byte_enable_n_oe", 1'h1, low_byte_enable_n_oe);
      wait_on(0, 1'h1, 9000);
      wait_on(0, 1'h0, 9000);
      axi_rd(STATE_OFFSET);
      chk("state_hs", 32'h40, rv & 32'h40);
      axi_rd(RESULT_OFFSET);
      chk_rng("inhibit", 998, 1004, rv & 32'h2FFF);
      send <= 1'h1;
      wait_on(4, 1'h1, 20);
      chk_rng("hs_old_lo", 230, 236, lo_bus);
      wait_on(3, 1'h1, 9000);
      chk("hs3_hi", 6'h07, hi_bus & 6'h2F);
      wait_on(4, 1'h1, 20);
      chk_rng("hs3_lo", 209, 213, lo_bus);
      $display("test mode held done");
      report_and_stop();
   end
endmodule
`default_nettype wire
